/* File: src/plt_regs.vh */
`ifndef PLT_REGS_VH
`define PLT_REGS_VH

`define PLT_CLK_KHZ 20000
`define PLT_CLK_NS 50

// Delay figures are in tenths of a millisecond
`define PLT_STEP_TMS 25
`define PLT_LIFT_TMS 75
`define PLT_DROP_TMS 300
`define PLT_TMS_CYC(t) ((t) * `PLT_CLK_KHZ / 10)

`define PLT_CLR_NS 100
`define PLT_CLR_CYC (`PLT_CLR_NS / `PLT_CLK_NS)

`define PLT_CNT_W 20
`define PLT_DEV_CODE 7'h60

`define PLT_OFF_CTRL 8'h00
`define PLT_OFF_STATUS 8'h04
`define PLT_OFF_STEP 8'h08
`define PLT_OFF_LIFT 8'h0c
`define PLT_OFF_DROP 8'h10

`define PLT_CTRL_ALT 0
`define PLT_CTRL_RESET 1'h0

`define PLT_ST_POWER 0
`define PLT_ST_BUSY 1
`define PLT_ST_DONE 2
`define PLT_ST_CHAN 3
`define PLT_ST_LATCH 6

`endif

/* File: src/plt_sync.v */
module plt_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_reg;

  // Only q may be read by other logic
  always @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // plt_sync

/* File: src/plt_oneshot.v */
`include "plt_regs.vh"

module plt_oneshot (
  input  wire                  clk,
  input  wire                  nrst,
  input  wire                  abort,
  input  wire                  start,
  input  wire [`PLT_CNT_W-1:0] count,
  output wire                  running,
  output reg                   expire
);

  reg [`PLT_CNT_W-1:0] cnt_reg;

  assign running = |cnt_reg;

  // Expire is the trailing edge: high in the same cycle the count reaches zero
  always @(posedge clk) begin
    if (!nrst || abort) begin
      cnt_reg <= {`PLT_CNT_W{1'b0}};
      expire  <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        cnt_reg <= (count == {`PLT_CNT_W{1'b0}}) ? {{(`PLT_CNT_W-1){1'b0}}, 1'b1} : count;
      end else if (running) begin
        cnt_reg <= cnt_reg - {{(`PLT_CNT_W-1){1'b0}}, 1'b1};
        if (cnt_reg == {{(`PLT_CNT_W-1){1'b0}}, 1'b1}) begin
          expire <= 1'b1;
        end
      end
    end
  end

endmodule // plt_oneshot

/* File: src/plt_ctrl.v */
// Implementation choices: register access over APB and the register offsets.
`include "plt_regs.vh"

// Operation
// - Output strobes act only while the select lines carry our code.
// - Our selection code is 140 octal, matched exactly.
// - Output clear: clear done, set busy, start first 2.5 ms delay.
// - Output load strobe latches bus bits 30 to 35.
// - Bit 32 sets carriage-left latch, driving carriage-left output.
// - First delay end pulses latch clear and starts second 2.5 ms delay.
// - Step completion sets done at second delay end, gated by lift finished.
// - Done becoming set clears busy.
// - While done, the stored channel drives one interrupt request line.
// - Latch clear drops pen raise, runs 7.5 ms, then sets done.
// - Bit 31 sets pen-lower latch driving the pen-down output.
// - Latch clear drops pen lower, runs two 30 ms delays, then done.
// - Bus reset makes a 100 ns clear of done, busy and channel.
// - Alternate build control clear also clears channel, done and busy.
// - Alternate build clear: crowbar-conditioned gate strobed by tape clock.
// - Status read: power 30, busy 31, done 32, channel 33 to 35.
// - Control set loads the channel from bits 33 to 35.
module plt_ctrl #(
  parameter [`PLT_CNT_W-1:0] STEP_CYC = `PLT_TMS_CYC(`PLT_STEP_TMS),
  parameter [`PLT_CNT_W-1:0] LIFT_CYC = `PLT_TMS_CYC(`PLT_LIFT_TMS),
  parameter [`PLT_CNT_W-1:0] DROP_CYC = `PLT_TMS_CYC(`PLT_DROP_TMS)
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [6:0]  dev_sel,
  input  wire [5:0]  iob_bits,
  input  wire        out_clear_strobe,
  input  wire        out_load_strobe,
  input  wire        ctl_clear_strobe,
  input  wire        ctl_set_strobe,
  input  wire        status_read_strobe,
  input  wire        bus_reset_level,
  input  wire        supply_crowbar_level,
  input  wire        tape_clock,
  input  wire        plotter_power,
  output reg  [5:0]  status_bits,
  output reg  [7:1]  pi_req,
  output wire        pen_up_drive,
  output wire        pen_down_drive,
  output wire        carriage_left_drive,
  output wire        carriage_right_drive,
  output wire        paper_advance_drive,
  output wire        paper_retreat_drive
);

  localparam NS = 22;
  // Clear length in clocks; a clock slower than 10 MHz would round it to nothing
  localparam integer CLR_CYC = `PLT_CLR_CYC;

  wire [NS-1:0]         sync_q;
  wire [6:0]            sel_s;
  wire [5:0]            iob_s;
  wire [4:0]            strb_s;
  wire                  reset_s;
  wire                  crowbar_s;
  wire                  tclk_s;
  wire                  power_s;
  reg  [4:0]            strb_prev_reg;
  reg                   reset_prev_reg;
  reg                   tclk_prev_reg;
  wire [4:0]            strb_rise;
  wire                  unit_selected;
  wire                  out_clear_sel;
  wire                  out_load_sel;
  wire                  ctl_clear_sel;
  wire                  ctl_set_sel;
  wire                  status_sel;

  reg                   alt_build_reg;
  reg  [`PLT_CNT_W-1:0] step_cnt_reg;
  reg  [`PLT_CNT_W-1:0] lift_cnt_reg;
  reg  [`PLT_CNT_W-1:0] drop_cnt_reg;

  reg                   plot_complete_flag;
  reg                   plot_active_flag;
  reg  [2:0]            chan_reg;
  reg                   pen_raise_latch;
  reg                   pen_lower_latch;
  reg  [3:0]            motion_reg;
  wire                  carriage_left_latch;

  reg  [1:0]            clr_cnt_reg;
  reg                   pwr_pend_reg;
  wire                  clr_trigger;
  wire                  internal_clear_level;
  wire                  alt_clear_strobe;
  wire                  control_clear_pulse;

  wire [4:0]            os_start;
  wire [5*`PLT_CNT_W-1:0] os_count;
  wire [4:0]            os_run;
  wire [4:0]            os_exp;
  wire                  latch_clear_pulse;
  wire                  step_finished_pulse;
  wire                  lift_finished_signal;
  wire                  drop_finished_pulse;
  wire                  done_set;

  wire                  apb_wr;
  wire                  apb_hit;
  reg  [31:0]           rd_next;
  wire [11:0]           status_word;

  // Every pin input crosses into clk through two flops
  plt_sync #(
    .W (NS)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({dev_sel, iob_bits, out_clear_strobe, out_load_strobe, ctl_clear_strobe,
            ctl_set_strobe, status_read_strobe, bus_reset_level, supply_crowbar_level,
            tape_clock, plotter_power}),
    .q    (sync_q)
  );

  assign sel_s     = sync_q[21:15];
  assign iob_s     = sync_q[14:9];
  assign strb_s    = sync_q[8:4];
  assign reset_s   = sync_q[3];
  assign crowbar_s = sync_q[2];
  assign tclk_s    = sync_q[1];
  assign power_s   = sync_q[0];

  always @(posedge clk) begin
    if (!nrst) begin
      strb_prev_reg  <= 5'h00;
      reset_prev_reg <= 1'b0;
      tclk_prev_reg  <= 1'b0;
    end else begin
      strb_prev_reg  <= strb_s;
      reset_prev_reg <= reset_s;
      tclk_prev_reg  <= tclk_s;
    end
  end

  // Edge detectors reset to the idle pin level, so no false edge follows reset
  assign strb_rise = strb_s & ~strb_prev_reg;

  assign unit_selected = (sel_s == `PLT_DEV_CODE);
  assign out_clear_sel = unit_selected & strb_rise[4];
  assign out_load_sel  = unit_selected & strb_rise[3];
  assign ctl_clear_sel = unit_selected & strb_rise[2];
  assign ctl_set_sel   = unit_selected & strb_rise[1];
  assign status_sel    = unit_selected & strb_s[0];

  // Clear sources: power-up, bus reset, or alternate build crowbar gate
  assign alt_clear_strobe = alt_build_reg & crowbar_s & tclk_s & ~tclk_prev_reg;
  assign clr_trigger = pwr_pend_reg | (reset_s & ~reset_prev_reg) | alt_clear_strobe;

  always @(posedge clk) begin
    if (!nrst) begin
      clr_cnt_reg  <= 2'h0;
      pwr_pend_reg <= 1'b1;
    end else begin
      pwr_pend_reg <= 1'b0;
      if (clr_trigger) begin
        clr_cnt_reg <= CLR_CYC[1:0];
      end else if (clr_cnt_reg != 2'h0) begin
        clr_cnt_reg <= clr_cnt_reg - 2'h1;
      end
    end
  end

  assign internal_clear_level = (clr_cnt_reg != 2'h0);
  // Same path serves both builds; only the name of the strobe differs
  assign control_clear_pulse = internal_clear_level | ctl_clear_sel;

  // One-shot chain: 0 first, 1 second step, 2 lift, 3 and 4 drop
  assign latch_clear_pulse = os_exp[0];
  assign os_start[0] = out_clear_sel;
  assign os_start[1] = latch_clear_pulse & (|motion_reg);
  assign os_start[2] = latch_clear_pulse & pen_raise_latch;
  assign os_start[3] = latch_clear_pulse & pen_lower_latch;
  assign os_start[4] = os_exp[3];
  assign os_count = {drop_cnt_reg, drop_cnt_reg, lift_cnt_reg, step_cnt_reg, step_cnt_reg};

  // Internal clear aborts delays in flight, so a reset never ends in a stray done
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_os
      plt_oneshot u_os (
        .clk     (clk),
        .nrst    (nrst),
        .abort   (internal_clear_level),
        .start   (os_start[gi]),
        .count   (os_count[gi*`PLT_CNT_W +: `PLT_CNT_W]),
        .running (os_run[gi]),
        .expire  (os_exp[gi])
      );
    end
  endgenerate

  // A step may only finish once no pen lift is still timing
  assign step_finished_pulse  = os_exp[1];
  assign lift_finished_signal = ~os_run[2];
  assign drop_finished_pulse  = os_exp[4];
  assign done_set = (step_finished_pulse & lift_finished_signal) | os_exp[2]
                    | drop_finished_pulse
                    | (ctl_set_sel & iob_s[2]);

  // Command latches; a load in the clearing cycle is kept
  // Repeated loads add bits; only a clear empties them
  always @(posedge clk) begin
    if (!nrst) begin
      pen_raise_latch <= 1'b0;
      pen_lower_latch <= 1'b0;
      motion_reg      <= 4'h0;
    end else if (out_load_sel) begin
      pen_raise_latch <= pen_raise_latch | iob_s[0];
      pen_lower_latch <= pen_lower_latch | iob_s[1];
      motion_reg      <= motion_reg | iob_s[5:2];
    end else if (latch_clear_pulse || internal_clear_level) begin
      pen_raise_latch <= 1'b0;
      pen_lower_latch <= 1'b0;
      motion_reg      <= 4'h0;
    end
  end

  assign carriage_left_latch  = motion_reg[0];
  assign pen_up_drive         = pen_raise_latch;
  assign pen_down_drive       = pen_lower_latch;
  assign carriage_left_drive  = carriage_left_latch;
  assign carriage_right_drive = motion_reg[1];
  assign paper_advance_drive  = motion_reg[2];
  assign paper_retreat_drive  = motion_reg[3];

  // Flags: a set in the same cycle as a clear wins
  always @(posedge clk) begin
    if (!nrst) begin
      plot_complete_flag <= 1'b0;
      plot_active_flag   <= 1'b0;
      chan_reg           <= 3'h0;
    end else begin
      if (done_set) begin
        plot_complete_flag <= 1'b1;
      end else if (control_clear_pulse || out_clear_sel) begin
        plot_complete_flag <= 1'b0;
      end
      if (out_clear_sel || (ctl_set_sel && iob_s[1])) begin
        plot_active_flag <= 1'b1;
      end else if (done_set || control_clear_pulse) begin
        plot_active_flag <= 1'b0;
      end
      // Bus bit 33 carries the channel's most significant bit
      if (ctl_set_sel) begin
        chan_reg <= {iob_s[3], iob_s[4], iob_s[5]};
      end else if (control_clear_pulse) begin
        chan_reg <= 3'h0;
      end
    end
  end

  // Channel 0 means no interrupt line
  // Lines are registered and follow the done flag one clock later
  generate
    for (gi = 1; gi < 8; gi = gi + 1) begin : g_pi
      always @(posedge clk) begin
        if (!nrst) begin
          pi_req[gi] <= 1'b0;
        end else begin
          pi_req[gi] <= plot_complete_flag & ({29'h0, chan_reg} == gi);
        end
      end
    end
  endgenerate

  // Status is driven while the selected read strobe stands, three clocks behind the pin, and is zero otherwise, leaving the shared bus free
  always @(posedge clk) begin
    if (!nrst) begin
      status_bits <= 6'h00;
    end else if (status_sel) begin
      status_bits <= {chan_reg[0], chan_reg[1], chan_reg[2], plot_complete_flag,
                      plot_active_flag, power_s};
    end else begin
      status_bits <= 6'h00;
    end
  end

  assign status_word = {motion_reg, pen_lower_latch, pen_raise_latch, chan_reg,
                        plot_complete_flag, plot_active_flag, power_s};

  // APB slave: zero wait states, read data captured in the setup cycle
  assign pready  = 1'b1;
  assign apb_hit = (paddr == `PLT_OFF_CTRL) || (paddr == `PLT_OFF_STATUS) ||
                   (paddr == `PLT_OFF_STEP) || (paddr == `PLT_OFF_LIFT) ||
                   (paddr == `PLT_OFF_DROP);
  assign pslverr = psel & penable & ~apb_hit;
  assign apb_wr  = psel & penable & pwrite & apb_hit;

  always @* begin
    rd_next = 32'h00000000;
    case (paddr)
      `PLT_OFF_CTRL:   rd_next[`PLT_CTRL_ALT] = alt_build_reg;
      `PLT_OFF_STATUS: rd_next[11:0] = status_word;
      `PLT_OFF_STEP:   rd_next[`PLT_CNT_W-1:0] = step_cnt_reg;
      `PLT_OFF_LIFT:   rd_next[`PLT_CNT_W-1:0] = lift_cnt_reg;
      `PLT_OFF_DROP:   rd_next[`PLT_CNT_W-1:0] = drop_cnt_reg;
      default:         rd_next = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_next;
    end
  end

  // Delay counts are writable so one build suits several mechanisms
  always @(posedge clk) begin
    if (!nrst) begin
      alt_build_reg <= `PLT_CTRL_RESET;
      step_cnt_reg  <= STEP_CYC;
      lift_cnt_reg  <= LIFT_CYC;
      drop_cnt_reg  <= DROP_CYC;
    end else if (apb_wr) begin
      case (paddr)
        `PLT_OFF_CTRL: alt_build_reg <= pwdata[`PLT_CTRL_ALT];
        `PLT_OFF_STEP: step_cnt_reg  <= pwdata[`PLT_CNT_W-1:0];
        `PLT_OFF_LIFT: lift_cnt_reg  <= pwdata[`PLT_CNT_W-1:0];
        `PLT_OFF_DROP: drop_cnt_reg  <= pwdata[`PLT_CNT_W-1:0];
        default:       alt_build_reg <= alt_build_reg;
      endcase
    end
  end

endmodule // plt_ctrl

/* File: tb/plt_asserts.sv */
module plt_asserts #(
  parameter int STEP_CYC = 40
) (
  input logic       clk,
  input logic       nrst,
  input logic [7:0] paddr,
  input logic       psel,
  input logic       penable,
  input logic       pready,
  input logic       pslverr,
  input logic [6:0] dev_sel,
  input logic       out_clear_strobe,
  input logic       status_read_strobe,
  input logic       bus_reset_level,
  input logic [5:0] status_bits,
  input logic [7:1] pi_req,
  input logic       carriage_left_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  sequence s_sel_clear;
    $rose(out_clear_strobe) && dev_sel == 7'h60;
  endsequence
  sequence s_step_start;
    $rose(carriage_left_drive);
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped");
  a_pi_onehot: assert property ($onehot0(pi_req)) else $error("pi lines");
  a_clear_pi: assert property (s_sel_clear |-> ##[1:6] pi_req == 7'h00)
    else $error("pi kept after clear");
  a_step_hold: assert property (s_step_start |-> carriage_left_drive[*8])
    else $error("step drive short");
  a_step_clear: assert property (s_step_start |-> ##[1:STEP_CYC] !carriage_left_drive)
    else $error("step drive stuck");
  a_bus_reset: assert property ($rose(bus_reset_level) |-> ##[1:6] pi_req == 7'h00)
    else $error("bus reset ignored");
  a_status_idle: assert property (!status_read_strobe[*6] |-> status_bits == 6'h00)
    else $error("status outside read");
endmodule // plt_asserts

bind plt_ctrl plt_asserts #(.STEP_CYC(STEP_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .dev_sel(dev_sel),
  .out_clear_strobe(out_clear_strobe), .status_read_strobe(status_read_strobe),
  .bus_reset_level(bus_reset_level), .status_bits(status_bits), .pi_req(pi_req),
  .carriage_left_drive(carriage_left_drive)
);

/* File: tb/plt_cpu_model.sv */
module plt_cpu_model (
  input  logic       clk,
  input  logic [5:0] status_bits,
  output logic [6:0] dev_sel,
  output logic [5:0] iob_bits,
  output logic       out_clear_strobe,
  output logic       out_load_strobe,
  output logic       ctl_clear_strobe,
  output logic       ctl_set_strobe,
  output logic       status_read_strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    dev_sel = 7'h1f;
    iob_bits = 6'h00;
    {out_clear_strobe, out_load_strobe, ctl_clear_strobe, ctl_set_strobe} = 4'h0;
    status_read_strobe = 1'b0;
  end
  // Strobes last 3 cycles so the two-stage input sync cannot miss them
  task automatic xfer(input logic ctl, input logic [6:0] code, input logic [5:0] bits);
    @(posedge clk);
    dev_sel <= code;
    iob_bits <= bits;
    @(posedge clk);
    if (ctl) ctl_clear_strobe <= 1'b1;
    else out_clear_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    ctl_clear_strobe <= 1'b0;
    out_clear_strobe <= 1'b0;
    repeat (17) @(posedge clk);
    if (ctl) ctl_set_strobe <= 1'b1;
    else out_load_strobe <= 1'b1;
    repeat (3) @(posedge clk);
    ctl_set_strobe <= 1'b0;
    out_load_strobe <= 1'b0;
    @(posedge clk);
    // Released lines show garbage, never the last value
    dev_sel <= ~code;
    iob_bits <= ~bits;
  endtask
  task automatic stat(output logic [5:0] s);
    @(posedge clk);
    dev_sel <= 7'h60;
    status_read_strobe <= 1'b1;
    repeat (5) @(posedge clk);
    s = status_bits;
    status_read_strobe <= 1'b0;
    dev_sel <= 7'h1f;
  endtask
endmodule // plt_cpu_model

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 40;
  localparam int L = 60;
  localparam int D = 100;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        bus_reset_level = 0, plotter_power = 0, crowbar = 0, tclk = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, seed = 40;
  logic        pready, pslverr, ocs, ols, ccs, css, srs;
  logic [6:0]  dev_sel;
  logic [5:0]  iob_bits, status_bits;
  wire  [5:0]  drv;
  logic [7:1]  pi_req;
  int          errors = 0, checks_done = 0, cyc = 0, t0;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  plt_ctrl #(.STEP_CYC(20'd40), .LIFT_CYC(20'd60), .DROP_CYC(20'd100)) DUT (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_sel(dev_sel), .iob_bits(iob_bits),
    .out_clear_strobe(ocs), .out_load_strobe(ols), .ctl_clear_strobe(ccs),
    .ctl_set_strobe(css), .status_read_strobe(srs),
    .bus_reset_level(bus_reset_level), .supply_crowbar_level(crowbar),
    .tape_clock(tclk), .plotter_power(plotter_power), .status_bits(status_bits),
    .pi_req(pi_req), .pen_up_drive(drv[0]), .pen_down_drive(drv[1]),
    .carriage_left_drive(drv[2]), .carriage_right_drive(drv[3]),
    .paper_advance_drive(drv[4]), .paper_retreat_drive(drv[5]));
  plt_cpu_model cpu (
    .clk(clk), .status_bits(status_bits), .dev_sel(dev_sel), .iob_bits(iob_bits),
    .out_clear_strobe(ocs), .out_load_strobe(ols), .ctl_clear_strobe(ccs),
    .ctl_set_strobe(css), .status_read_strobe(srs));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_cyc(int i);
    return (i == 0) ? S + L : (i == 1) ? S + 2 * D : 2 * S;
  endfunction
  function automatic logic [31:0] exp_st(logic p, logic b, logic d, logic [2:0] c);
    return {26'h0, c[0], c[1], c[2], d, b, p};
  endfunction
  // Line n of the interrupt request sits at bit n-1 of the packed word
  function automatic logic [31:0] exp_pi(logic [2:0] c);
    return (c == 3'h0) ? 32'h0 : (32'h1 << (c - 3'h1));
  endfunction
  task automatic cmp_word(logic [31:0] g, logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_range(int g, int lo, int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      errors++;
      $display("[ERR] %0t took %0d cycles, expected %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tpulse();
    @(posedge clk);
    tclk <= 1'b1;
    repeat (3) @(posedge clk);
    tclk <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic summarize();
    if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [5:0]  s;
    logic [2:0]  ch;
    logic [6:0]  bad;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    r = xs();
    plotter_power <= r[0];
    repeat (6) @(posedge clk);
    apb(1'b1, 8'h08, 32'd40, r, e);
    apb(1'b0, 8'h08, 32'h0, r, e);
    cmp_word({r[30:0], e}, 32'd80);
    apb(1'b0, 8'h44, 32'h0, r, e);
    cmp_word({r[30:0], e}, 32'h1);
    r = xs();
    ch = (r[2:0] == 3'h0) ? 3'h5 : r[2:0];
    cpu.xfer(1'b1, 7'h60, {ch[0], ch[1], ch[2], 3'b100});
    repeat (6) @(posedge clk);
    cmp_word({25'h0, pi_req}, exp_pi(ch));
    for (int i = 0; i < 6; i++) begin
      t0 = cyc;
      cpu.xfer(1'b0, 7'h60, 6'h1 << i);
      repeat (3) @(posedge clk);
      cmp_word({26'h0, drv}, 32'h1 << i);
      cpu.stat(s);
      cmp_word({26'h0, s}, exp_st(plotter_power, 1'b1, 1'b0, ch));
      for (int n = 0; n < 400 && pi_req === 7'h00; n++) @(posedge clk);
      cmp_range(cyc - t0, exp_cyc(i), exp_cyc(i) + 14);
      cmp_word({26'h0, drv}, 32'h0);
      cpu.stat(s);
      cmp_word({26'h0, s}, exp_st(plotter_power, 1'b0, 1'b1, ch));
      cmp_word({25'h0, pi_req}, exp_pi(ch));
    end
    r = xs();
    bad = (r[6:0] == 7'h60) ? 7'h61 : r[6:0];
    cpu.xfer(1'b0, bad, 6'h04);
    repeat (4) @(posedge clk);
    cmp_word({26'h0, drv}, 32'h0);
    cmp_word({25'h0, pi_req}, exp_pi(ch));
    plotter_power <= ~plotter_power;
    bus_reset_level <= 1'b1;
    repeat (3) @(posedge clk);
    bus_reset_level <= 1'b0;
    repeat (6) @(posedge clk);
    cmp_word({25'h0, pi_req}, 32'h0);
    cpu.stat(s);
    cmp_word({26'h0, s}, exp_st(plotter_power, 1'b0, 1'b0, 3'h0));
    cpu.xfer(1'b1, 7'h60, {ch[0], ch[1], ch[2], 3'b010});
    crowbar <= 1'b1;
    tpulse();
    cpu.stat(s);
    cmp_word({26'h0, s}, exp_st(plotter_power, 1'b1, 1'b0, ch));
    apb(1'b1, 8'h00, 32'h1, r, e);
    apb(1'b0, 8'h00, 32'h0, r, e);
    cmp_word({r[30:0], e}, 32'h2);
    tpulse();
    cpu.stat(s);
    cmp_word({26'h0, s}, exp_st(plotter_power, 1'b0, 1'b0, 3'h0));
    summarize();
  end
endmodule // tb
